// ===== rtl/dmats_cfg.svh
// Functional notes
// - trigger select bits 2:0 pick start event
// - codes 0-6 map to seven event inputs
// - code 111B: start only on software launch
// - halt bit 0 stops transfers; resets zero
// - lower level waits until higher completes
// - higher level waits, then preempts lower level
// - every level waits before moving
// - bits 22/21/20 show busy bus
// - bits 17/16 show level 1/0 preempted
// - level 2 waiting bit 13, moving 12
// - level 1 waiting bit 19, moving 8
// - level 0 waiting bit 5, moving 4
// - signal-processor channel waiting 1, moving 0
// - state flags read-only, live, reset zero
// - launch bit 0 works only with 111B
// - arm bit 8 arms level for trigger
// - configuration writes blocked while level moves
`ifndef DMATS_CFG_SVH
`define DMATS_CFG_SVH

`define DMATS_LVL_BASE     32'h05FE0000
`define DMATS_LVL_STRIDE   32'h00000020
`define DMATS_ARM_OFS      32'h00000010
`define DMATS_MODE_OFS     32'h00000014
`define DMATS_HALT_ADDR    32'h05FE0060
`define DMATS_STAT_ADDR    32'h05FE007C

`define DMATS_ARM_BIT      8
`define DMATS_LAUNCH_BIT   0
`define DMATS_HALT_BIT     0
`define DMATS_TRIG_LSB     0
`define DMATS_BUS_LSB      4
`define DMATS_TRIG_SW      3'h7
`define DMATS_TRIG_RESET   3'h7
`define DMATS_BUS_RESET    2'h0
`define DMATS_BUS_A        2'h0
`define DMATS_BUS_B        2'h1
`define DMATS_BUS_SP       2'h2
`define DMATS_STAT_RESET   32'h00000000

`define DMATS_ST_SP_BUS    22
`define DMATS_ST_B_BUS     21
`define DMATS_ST_A_BUS     20
`define DMATS_ST_L1_WT     19
`define DMATS_ST_L1_BK     17
`define DMATS_ST_L0_BK     16
`define DMATS_ST_L2_WT     13
`define DMATS_ST_L2_MV     12
`define DMATS_ST_L1_MV     8
`define DMATS_ST_L0_WT     5
`define DMATS_ST_L0_MV     4
`define DMATS_ST_SP_WT     1
`define DMATS_ST_SP_MV     0

`define DMATS_XFER_WORDS   16
`define DMATS_FIFO_DEPTH   16

`endif

// ===== rtl/dmats_pkg.sv
package dmats_pkg;
    typedef enum logic [3:0] {
        DMATS_IDLE = 4'b0001,
        DMATS_WAIT = 4'b0010,
        DMATS_MOVE = 4'b0100,
        DMATS_HELD = 4'b1000
    } dmats_state_t;
endpackage

// ===== rtl/dmats_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dmats_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic                       mclk,      // system clock
    input  wire logic                       rstn,      // async reset, low
    input  wire logic                       in_valid,  // write request
    input  wire logic [W-1:0]               in_data,   // write word
    output logic                            in_ready,  // room in memory
    output logic                            out_valid, // head word valid
    output logic [W-1:0]                    out_data,  // head word
    input  wire logic                       out_ready, // head taken
    output logic [$clog2(DEPTH+1)-1:0]      used       // words in memory
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
            $error("dmats_fifo: DEPTH must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    ov;
        logic [W-1:0]            od;
    } dmats_fifo_s_t;

    dmats_fifo_s_t q;
    dmats_fifo_s_t n;
    logic          push;
    logic          pop;

    always_comb begin
        n    = q;
        push = in_valid && (q.cnt != CW'(DEPTH));
        // head register refills whenever it is empty or being taken
        pop  = (q.cnt != '0) && (!q.ov || out_ready);
        if (push) begin
            n.mem[q.wp] = in_data;
            n.wp        = q.wp + 1'b1;
        end
        if (pop) begin
            n.od = q.mem[q.rp];
            n.ov = 1'b1;
            n.rp = q.rp + 1'b1;
        end else if (out_ready) begin
            n.ov = 1'b0;
        end
        if (push && !pop) begin
            n.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            n.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign in_ready  = q.cnt != CW'(DEPTH);
    assign out_valid = q.ov;
    assign out_data  = q.od;
    assign used      = q.cnt;
endmodule
`default_nettype wire

// ===== rtl/dmats_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmats_cfg.svh"
module dmats_top #(
    parameter int W          = 32,
    parameter int FIFO_DEPTH = `DMATS_FIFO_DEPTH,
    parameter int XFER_WORDS = `DMATS_XFER_WORDS
) (
    input  wire logic          mclk,            // system clock, 125 MHz
    input  wire logic          rstn,            // async reset, low
    input  wire logic [31:0]   avs_address,     // byte address
    input  wire logic          avs_read,        // read request
    input  wire logic          avs_write,       // write request
    input  wire logic [31:0]   avs_writedata,   // write data
    output logic      [31:0]   avs_readdata,    // read data
    output logic               avs_waitrequest, // stall
    input  wire logic [6:0]    ext_evt,         // external start events
    input  wire logic          sp_req,          // signal-processor dma request
    input  wire logic          src_valid,       // source word valid
    input  wire logic [W-1:0]  src_data,        // source word
    output logic               src_ready,       // source word taken
    output logic               snk_valid,       // sink word valid
    output logic [W-1:0]       snk_data,        // sink word
    input  wire logic          snk_ready        // sink accepts
);
    import dmats_pkg::*;

    localparam int CW  = 16;
    localparam int FCW = $clog2(FIFO_DEPTH+1);
    localparam int NCH = 4;
    localparam int SPC = 3;

    generate
        if (XFER_WORDS < 1 || XFER_WORDS >= (1 << CW)) begin : g_bad_xfer
            $error("dmats_top: XFER_WORDS out of range");
        end
        if (FIFO_DEPTH < 2) begin : g_bad_depth
            $error("dmats_top: FIFO_DEPTH too small");
        end
        if (W < 1) begin : g_bad_width
            $error("dmats_top: W must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic                          waitreq;
        logic [31:0]                   rdata;
        logic [6:0]                    evt_prev;
        logic [2:0]                    arm;
        logic [2:0][2:0]               trig;
        logic [2:0][1:0]               bus;
        dmats_state_t [NCH-1:0]        st;
        logic [NCH-1:0][CW-1:0]        left;
        logic                          src_rdy;
    } dmats_regs_t;

    dmats_regs_t    q;
    dmats_regs_t    n;

    logic           fifo_in_ready;
    logic [FCW-1:0] fifo_used;
    logic           accept;

    // channel 3 is the signal-processor channel, ranked below level 0
    function automatic logic [2:0] rank(input int ch);
        rank = (ch == SPC) ? 3'h1 : 3'(ch + 2);
    endfunction

    function automatic logic [31:0] lvl_addr(input int lvl, input logic [31:0] ofs);
        lvl_addr = `DMATS_LVL_BASE + 32'(lvl) * `DMATS_LVL_STRIDE + ofs;
    endfunction

    // a waiting or held channel still competes for the bus
    function automatic logic pending(input dmats_state_t s);
        pending = (s == DMATS_WAIT) || (s == DMATS_HELD);
    endfunction

    // register hit inside one level's block
    function automatic logic lvl_hit(input int lvl, input logic [31:0] ofs, input logic [31:0] a);
        lvl_hit = (a == lvl_addr(lvl, ofs));
    endfunction

    always_comb begin
        logic          wr_go;
        logic          halt;
        logic [6:0]    rise;
        logic [NCH-1:0] launch;
        logic [31:0]   stat;
        logic [2:0]    mv_rank;
        int            mv;
        int            best;
        logic [2:0]    best_rank;
        logic          mv_done;
        logic          mv_next;
        logic [1:0]    mv_bus;

        n         = q;
        wr_go     = avs_write && !q.waitreq;
        halt      = 1'b0;
        rise      = '0;
        launch    = '0;
        stat      = `DMATS_STAT_RESET;
        mv_rank   = '0;
        mv        = 0;
        best      = 0;
        best_rank = '0;
        mv_done   = 1'b0;
        mv_next   = 1'b0;
        mv_bus    = '0;

        // present mover and its bus
        for (int c = 0; c < NCH; c++) begin
            if (q.st[c] == DMATS_MOVE) begin
                mv      = c;
                mv_rank = rank(c);
                mv_bus  = (c == SPC) ? `DMATS_BUS_SP : q.bus[c];
            end
        end

        // live state flags
        // live read-only word
        if (mv_rank != '0) begin
            stat[`DMATS_ST_SP_BUS] = (mv_bus == `DMATS_BUS_SP);
            stat[`DMATS_ST_B_BUS]  = (mv_bus == `DMATS_BUS_B);
            stat[`DMATS_ST_A_BUS]  = (mv_bus == `DMATS_BUS_A);
        end
        stat[`DMATS_ST_L1_BK] = (q.st[1] == DMATS_HELD);
        stat[`DMATS_ST_L0_BK] = (q.st[0] == DMATS_HELD);
        stat[`DMATS_ST_L2_WT] = (q.st[2] == DMATS_WAIT);
        stat[`DMATS_ST_L2_MV] = (q.st[2] == DMATS_MOVE);
        stat[`DMATS_ST_L1_WT] = (q.st[1] == DMATS_WAIT);
        stat[`DMATS_ST_L1_MV] = (q.st[1] == DMATS_MOVE);
        stat[`DMATS_ST_L0_WT] = (q.st[0] == DMATS_WAIT);
        stat[`DMATS_ST_L0_MV] = (q.st[0] == DMATS_MOVE);
        // channel has no preempted flag, so held shows as waiting
        stat[`DMATS_ST_SP_WT] = pending(q.st[SPC]);
        stat[`DMATS_ST_SP_MV] = (q.st[SPC] == DMATS_MOVE);

        // bus handshake: one stall cycle, then a single ready cycle
        if (q.waitreq) begin
            if (avs_read || avs_write) begin
                n.waitreq = 1'b0;
            end
            if (avs_read) begin
                n.rdata = (avs_address == `DMATS_STAT_ADDR) ? stat : 32'h00000000;
            end
        end else begin
            n.waitreq = 1'b1;
        end

        // edge detect, one request per event
        rise       = ext_evt & ~q.evt_prev;
        n.evt_prev = ext_evt;

        for (int l = 0; l < 3; l++) begin
            if (wr_go && q.st[l] != DMATS_MOVE) begin
                if (lvl_hit(l, `DMATS_ARM_OFS, avs_address)) begin
                    n.arm[l] = avs_writedata[`DMATS_ARM_BIT];
                    launch[l] = avs_writedata[`DMATS_LAUNCH_BIT]
                              && avs_writedata[`DMATS_ARM_BIT]
                              && (q.trig[l] == `DMATS_TRIG_SW);
                end
                if (lvl_hit(l, `DMATS_MODE_OFS, avs_address)) begin
                    n.trig[l] = avs_writedata[`DMATS_TRIG_LSB +: 3];
                    n.bus[l]  = avs_writedata[`DMATS_BUS_LSB +: 2];
                end
            end
            // selected event starts an armed level
            if (q.arm[l] && q.trig[l] != `DMATS_TRIG_SW && rise[q.trig[l]]) begin
                launch[l] = 1'b1;
            end
        end
        launch[SPC] = sp_req;

        for (int c = 0; c < NCH; c++) begin
            if (q.st[c] == DMATS_IDLE && launch[c]) begin
                n.st[c]   = DMATS_WAIT;
                n.left[c] = CW'(XFER_WORDS);
            end
        end

        // word counting for the mover
        if (mv_rank != '0 && accept) begin
            n.left[mv] = q.left[mv] - 1'b1;
            if (q.left[mv] == CW'(1)) begin
                mv_done  = 1'b1;
                n.st[mv] = DMATS_IDLE;
            end
        end

        // highest ranked waiting or held channel
        for (int c = 0; c < NCH; c++) begin
            if (pending(q.st[c]) && rank(c) > best_rank) begin
                best      = c;
                best_rank = rank(c);
            end
        end

        if (best_rank != '0) begin
            if (mv_rank == '0 || mv_done) begin
                // lower level runs after higher completes
                n.st[best] = DMATS_MOVE;
            end else if (q.st[best] == DMATS_WAIT && best_rank > mv_rank) begin
                n.st[mv]   = DMATS_HELD;
                n.st[best] = DMATS_MOVE;
            end
        end

        halt = wr_go && (avs_address == `DMATS_HALT_ADDR)
            && avs_writedata[`DMATS_HALT_BIT];
        if (halt) begin
            for (int c = 0; c < NCH; c++) begin
                n.st[c] = DMATS_IDLE;
            end
        end

        for (int c = 0; c < NCH; c++) begin
            if (n.st[c] == DMATS_MOVE) begin
                mv_next = 1'b1;
            end
        end
        // ready is registered, so grant it only with a slot to spare
        n.src_rdy = mv_next
                 && ({1'b0, fifo_used} + {{FCW{1'b0}}, accept} < (FCW+1)'(FIFO_DEPTH));
    end

    assign accept = q.src_rdy && src_valid && fifo_in_ready;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q.waitreq  <= 1'b1;
            q.rdata    <= '0;
            q.evt_prev <= '0;
            q.arm      <= '0;
            q.left     <= '0;
            q.src_rdy  <= 1'b0;
            for (int c = 0; c < 3; c++) begin
                q.trig[c] <= `DMATS_TRIG_RESET;
                q.bus[c]  <= `DMATS_BUS_RESET;
            end
            // element-wise so every channel holds a legal one-hot code
            for (int c = 0; c < NCH; c++) begin
                q.st[c] <= DMATS_IDLE;
            end
        end else begin
            q <= n;
        end
    end

    dmats_fifo #(
        .W     (W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (accept),
        .in_data   (src_data),
        .in_ready  (fifo_in_ready),
        .out_valid (snk_valid),
        .out_data  (snk_data),
        .out_ready (snk_ready),
        .used      (fifo_used)
    );

    assign avs_readdata    = q.rdata;
    assign avs_waitrequest = q.waitreq;
    assign src_ready       = q.src_rdy;
endmodule
`default_nettype wire

// ===== bench/dmats_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmats_cfg.svh"
module dmats_monitor #(
    parameter int W = 32
) (
    input wire logic         mclk,            // clock
    input wire logic         rstn,            // reset, low
    input wire logic [31:0]  avs_address,     // address
    input wire logic         avs_read,        // read
    input wire logic         avs_write,       // write
    input wire logic [31:0]  avs_readdata,    // read data
    input wire logic         avs_waitrequest, // stall
    input wire logic         snk_valid,       // sink valid
    input wire logic [W-1:0] snk_data,        // sink word
    input wire logic         snk_ready        // sink accepts
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic        st_rd;
    logic [31:0] rd;
    // flags are judged only at the edge the master takes them
    assign st_rd = avs_read && !avs_waitrequest && avs_address == `DMATS_STAT_ADDR;
    assign rd    = avs_readdata;
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one stall");
    wait_gap_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    halt_ro_a: assert property (
        avs_read && !avs_waitrequest && avs_address == `DMATS_HALT_ADDR |-> rd == 32'h0)
        else $error("halt register read not zero");
    rsvd_zero_a: assert property (st_rd |-> (rd & 32'hFF84CECC) == 32'h0)
        else $error("unused status bit set");
    one_mover_a: assert property (st_rd |-> $onehot0({rd[12], rd[8], rd[4], rd[0]}))
        else $error("two channels moving");
    bus_flag_a: assert property (
        st_rd && |rd[22:20] |-> $onehot0(rd[22:20]) && (rd[12] || rd[8] || rd[4] || rd[0]))
        else $error("bus flag without mover");
    held_cause_a: assert property (
        st_rd && (rd[17] || rd[16]) |-> rd[12] || (rd[8] && !rd[17]))
        else $error("held level without higher mover");
    wt_mv_a: assert property (
        st_rd |-> !(rd[13] && rd[12]) && !(rd[19] && rd[8]) && !(rd[5] && rd[4]))
        else $error("level waiting and moving");
    snk_hold_a: assert property (snk_valid && !snk_ready |=> snk_valid && $stable(snk_data))
        else $error("sink word dropped while stalled");
    cover property (st_rd && rd[17]);
    cover property (st_rd && rd[1]);
    cover property (snk_valid && snk_ready);
endmodule
bind dmats_top dmats_monitor #(.W(W)) u_mon (
    .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .snk_valid(snk_valid), .snk_data(snk_data), .snk_ready(snk_ready)
);
`default_nettype wire

// ===== bench/dmats_partner.sv
`timescale 1ns/1ps
`default_nettype none
module dmats_partner #(
    parameter int W = 32
) (
    input wire logic     mclk,      // clock
    input wire logic     rstn,      // reset, low
    input wire logic     src_en,    // source may offer
    output logic         src_valid, // source valid
    output logic [W-1:0] src_data,  // source word
    input wire logic     src_ready, // source taken
    output logic         snk_ready  // sink accepts
);
    int           seed = 68155;
    logic [W-1:0] word_r;
    // an idle source shows junk so a stale word never passes as valid
    assign src_data = src_valid ? word_r : ~word_r;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            src_valid <= 1'b0;
            word_r    <= {W{1'b0}};
            snk_ready <= 1'b0;
        end else begin
            // sink stalls about one cycle in four
            snk_ready <= ($random(seed) & 3) != 0;
            // an offered word stays until taken
            src_valid <= src_en || (src_valid && !src_ready);
            if (src_valid && src_ready) begin
                word_r <= $random(seed);
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/dmats_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmats_cfg.svh"
module dmats_tb_top;
    localparam int XW = 4;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [31:0] avs_address = 32'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [6:0]  ext_evt = 7'h00;
    logic        sp_req = 1'b0;
    logic        src_en = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        src_valid;
    logic        src_ready;
    logic        snk_valid;
    logic        snk_ready;
    logic [31:0] src_data;
    logic [31:0] snk_data;
    logic [31:0] rd_val;
    logic [31:0] exp_rd[$];
    logic [31:0] exp_snk[$];
    int          num_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    dmats_top #(.XFER_WORDS(XW)) DUT (
        .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_evt(ext_evt), .sp_req(sp_req),
        .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
        .snk_valid(snk_valid), .snk_data(snk_data), .snk_ready(snk_ready)
    );
    dmats_partner u_far (
        .mclk(mclk), .rstn(rstn), .src_en(src_en), .src_valid(src_valid),
        .src_data(src_data), .src_ready(src_ready), .snk_ready(snk_ready)
    );
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic end_of_test;
        $display("comparisons %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // results are compared where they appear, against the oldest note
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (avs_read && avs_waitrequest === 1'b0 && exp_rd.size() > 0) begin
            check("read data", avs_readdata, exp_rd.pop_front());
        end
        if (src_valid && src_ready === 1'b1) begin
            exp_snk.push_back(src_data);
        end
        if (snk_valid === 1'b1 && snk_ready) begin
            check("sink word", snk_data, exp_snk.size() > 0 ? exp_snk.pop_front() : 32'hX);
        end
        // the limit is the last step of this process, so nothing follows the finish
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        rd_val = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        repeat (4) @(posedge mclk);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wait_idle;
        rd_val = 32'h1;
        while (rd_val !== 32'h0) begin
            bus(1'b0, `DMATS_STAT_ADDR, 32'h0);
        end
    endtask
    function automatic logic [31:0] lv(input int l, input logic [31:0] ofs);
        return `DMATS_LVL_BASE + `DMATS_LVL_STRIDE * l + ofs;
    endfunction
    task automatic cfg(input int l, input logic [2:0] c, input logic [1:0] b, input logic [31:0] arm);
        bus(1'b1, lv(l, `DMATS_MODE_OFS), {26'h0, b, 1'b0, c});
        bus(1'b1, lv(l, `DMATS_ARM_OFS), arm);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rd_chk(`DMATS_STAT_ADDR, 32'h0); // reset value
        bus(1'b1, `DMATS_STAT_ADDR, 32'hFFFFFFFF);
        rd_chk(`DMATS_STAT_ADDR, 32'h0); // write ignored
        rd_chk(`DMATS_HALT_ADDR, 32'h0); // reads zero
        rd_chk(32'h05FE00F0, 32'h0); // unmapped reads zero
        for (int k = 0; k < 7; k++) begin
            ext_evt <= 7'h00;
            cfg(0, k[2:0], 2'(k % 3), 32'h100);
            ext_evt <= ~(7'h01 << k);
            rd_chk(`DMATS_STAT_ADDR, 32'h0); // other events ignored
            ext_evt <= 7'h7F;
            rd_chk(`DMATS_STAT_ADDR, 32'h10 | (32'h1 << (20 + k % 3))); // chosen event
            src_en <= 1'b1;
            wait_idle();
            src_en <= 1'b0;
            rd_chk(`DMATS_STAT_ADDR, 32'h0); // one event one run
        end
        ext_evt <= 7'h00;
        cfg(0, 3'h7, 2'h0, 32'h100);
        ext_evt <= 7'h7F;
        rd_chk(`DMATS_STAT_ADDR, 32'h0); // events ignored
        bus(1'b1, lv(0, `DMATS_ARM_OFS), 32'h101);
        rd_chk(`DMATS_STAT_ADDR, 32'h00100010); // level 0 moves
        cfg(1, 3'h7, 2'h1, 32'h101);
        rd_chk(`DMATS_STAT_ADDR, 32'h00210100); // level 1 preempts
        cfg(2, 3'h7, 2'h2, 32'h101);
        rd_chk(`DMATS_STAT_ADDR, 32'h00431000); // both held
        cfg(2, 3'h0, 2'h0, 32'h100);
        sp_req <= 1'b1;
        @(posedge mclk);
        sp_req <= 1'b0;
        rd_chk(`DMATS_STAT_ADDR, 32'h00431002); // blocked, waiting
        src_en <= 1'b1;
        wait_idle();
        rd_chk(`DMATS_STAT_ADDR, 32'h0); // one run per launch
        src_en <= 1'b0;
        bus(1'b1, lv(0, `DMATS_ARM_OFS), 32'h101);
        bus(1'b1, lv(1, `DMATS_ARM_OFS), 32'h101);
        rd_chk(`DMATS_STAT_ADDR, 32'h00210100); // level 1 moves
        bus(1'b1, `DMATS_HALT_ADDR, 32'h1);
        rd_chk(`DMATS_STAT_ADDR, 32'h0); // halt clears all
        check("source ready", {31'h0, src_ready}, 32'h0); // transfer stopped
        repeat (200) @(posedge mclk);
        check("words left", exp_snk.size(), 32'h0); // taken words drained
        end_of_test();
    end
endmodule
`default_nettype wire
